// ==== pcg_clock_gen.sv ====
// Palette clock generator: source select, divided clocks, APB registers
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
module pcg_clock_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire pcg_pkg::pcg_apb_req_s apbReq,
  output pcg_pkg::pcg_apb_rsp_s apbRsp,
  input wire logic clockInputZero,
  input wire logic clockInputOne,
  input wire logic clockInputTwo,
  input wire logic clockInputThree,
  input wire logic clockInputFour,
  input wire pcg_pkg::pcg_vid_s vidIn,
  output pcg_pkg::pcg_clk_s clkOut,
  output pcg_pkg::pcg_vid_s vidSampled,
  output pcg_pkg::pcg_src_s srcOut,
  output logic settling
);
  import pcg_pkg::*;

  // The dot clock is clk/2: counter bit 0 is the dot clock itself, so
  // every ratio including /1 leaves a flop with a clean 50 percent duty.
  function automatic logic tapBit(input logic [6:0] c, input logic [2:0] sel);
    logic [7:0] ext;
    ext = {1'b0, c};
    tapBit = ext[sel];
  endfunction

  // Returns {valid, index, diff}; bits 3 to 7 take no part
  function automatic logic [4:0] decodeSrc(input logic [7:0] code);
    logic [4:0] r;
    r = 5'h00;
    unique case (code[2:0])
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4: r = {1'b1, code[2:0], 1'b0};
      3'h6: r = {1'b1, 3'h3, 1'b1};
      3'h7: r = {1'b1, 3'h1, 1'b1};
      default: r = 5'h00;
    endcase
    decodeSrc = r;
  endfunction

  logic rstMeta;
  logic rstSyncN;
  logic [7:0] pinRaw;
  logic [7:0] pinSync;
  logic [4:0] clkPins;
  pcg_vid_s vidPins;
  pcg_state_s s;
  pcg_state_s n;
  logic setup;
  logic access;
  logic wrOcs;
  logic wrIcs;
  logic wrCfg;
  logic cntReset;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  assign pinRaw = {vidIn.hsync, vidIn.vsync, vidIn.systemBlankIn, clockInputFour,
    clockInputThree, clockInputTwo, clockInputOne, clockInputZero};

  pcg_sync_bank u_sync (
    .clk(clk),
    .rstSyncN(rstSyncN),
    .din(pinRaw),
    .dout(pinSync)
  );

  assign clkPins = pinSync[4:0];
  assign vidPins = pinSync[7:5];

  assign setup = apbReq.psel && !apbReq.penable;
  assign access = apbReq.psel && apbReq.penable && s.rsp.pready && !s.rsp.pslverr;
  assign wrOcs = access && apbReq.pwrite && apbReq.paddr == OCS_ADDR;
  assign wrIcs = access && apbReq.pwrite && apbReq.paddr == ICS_ADDR;
  assign wrCfg = access && apbReq.pwrite && apbReq.paddr == CFG_ADDR;
  assign cntReset = wrOcs && apbReq.pwdata[6:0] == CNT_RESET_CODE;

  always_comb begin
    logic [4:0] dec;
    logic edgeHit;
    logic [2:0] refSel;
    logic [2:0] vidSel;
    dec = decodeSrc(apbReq.pwdata[7:0]);
    edgeHit = 1'b0;
    refSel = 3'h0;
    vidSel = 3'h0;
    n = s;

    // Register bus: answer prepared in setup, presented in the access phase
    n.rsp.pready = setup;
    n.rsp.pslverr = 1'b0;
    if (setup) begin
      unique case (apbReq.paddr)
        OCS_ADDR: n.rsp.prdata = {24'h0, s.ocs};
        ICS_ADDR: n.rsp.prdata = {24'h0, s.ics};
        CFG_ADDR: n.rsp.prdata = {31'h0, s.cfgInvert};
        STAT_ADDR: begin
          n.rsp.prdata = 32'h0;
          n.rsp.prdata[ST_REF] = s.clk.refClk;
          n.rsp.prdata[ST_SHIFT] = s.clk.shiftClk;
          n.rsp.prdata[ST_VIDEO] = s.clk.videoClockOut;
          n.rsp.prdata[ST_SETTLE] = s.busy;
          n.rsp.prdata[ST_HSYNC] = s.vid.hsync;
          n.rsp.prdata[ST_VSYNC] = s.vid.vsync;
          n.rsp.prdata[ST_BLANK] = s.vid.systemBlankIn;
          n.rsp.prdata[ST_LEVEL] = s.src.level;
          n.rsp.prdata[ST_CNT_LSB +: 7] = s.cnt;
        end
        default: begin
          n.rsp.prdata = 32'h0;
          n.rsp.pslverr = 1'b1;
        end
      endcase
    end

    if (wrOcs) begin
      n.ocs = apbReq.pwdata[7:0];
    end
    if (wrIcs) begin
      n.ics = apbReq.pwdata[7:0];
      if (dec[4]) begin
        n.src.index = dec[3:1];
        n.src.diff = dec[0];
        n.src.double = apbReq.pwdata[ICS_DOUBLE];
      end
    end
    if (wrCfg) begin
      n.cfgInvert = apbReq.pwdata[0];
    end

    // Settling window after a selection change, shown in the status word
    if (wrOcs || wrIcs) begin
      n.settle = SETTLE_CYC;
    end else if (s.settle != 3'h0) begin
      n.settle = s.settle - 3'h1;
    end
    n.busy = n.settle != 3'h0;

    // Level of the chosen source; a differential pair is high when p beats n
    if (s.src.diff) begin
      n.src.level = clkPins[s.src.index] && !clkPins[s.src.index + 3'h1];
    end else begin
      n.src.level = clkPins[s.src.index];
    end

    // One shared counter feeds all three outputs, keeping them in phase
    n.cnt = cntReset ? 7'h00 : s.cnt + 7'h01;
    refSel = n.ocs[OCS_REF_LSB +: 3];
    vidSel = n.ocs[OCS_VID_LSB +: 3];

    // Reference never sees blank; held code forces it low
    n.clk.refClk = refSel == HELD_CODE ? 1'b0 : tapBit(n.cnt, refSel);
    // A running shift high phase completes; a new one starts only unblanked
    n.clk.shiftClk = n.ocs[OCS_SHIFT_EN] && n.clk.refClk
      && (s.clk.shiftClk || s.vid.systemBlankIn);
    n.clk.videoClockOut = vidSel == HELD_CODE ? 1'b1 : tapBit(n.cnt, vidSel);

    // Video controls are taken at the chosen video clock edge
    if (s.cfgInvert) begin
      edgeHit = !s.clk.videoClockOut && n.clk.videoClockOut;
    end else begin
      edgeHit = s.clk.videoClockOut && !n.clk.videoClockOut;
    end
    if (edgeHit) begin
      n.vid = vidPins;
    end
  end

  // Reset values give /64 reference, shift low, video high, input zero TTL
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      s <= STATE_RST;
    end else begin
      s <= n;
    end
  end

  assign apbRsp = s.rsp;
  assign clkOut = s.clk;
  assign vidSampled = s.vid;
  assign srcOut = s.src;
  assign settling = s.busy;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstSyncN);

  a_ref_div_one: assert property (
    s.ocs[2:0] == 3'h0 && $past(s.ocs[2:0]) == 3'h0 && !$past(cntReset)
      |-> clkOut.refClk != $past(clkOut.refClk))
    else $error("reference clock not toggling at divide by one");

  a_video_held: assert property (
    $past(s.ocs[5:3]) == 3'h7 && s.ocs[5:3] == 3'h7 |-> clkOut.videoClockOut [*1])
    else $error("video clock not held high");

  a_ref_shift_held: assert property (
    s.ocs[2:0] == 3'h7 |-> !clkOut.refClk && !clkOut.shiftClk)
    else $error("reference or shift clock not held low");

  a_shift_disabled: assert property (
    !s.ocs[6] |-> !clkOut.shiftClk)
    else $error("shift clock active while disabled");

  a_shift_blanked: assert property (
    $rose(clkOut.shiftClk) |-> $past(s.vid.systemBlankIn) && clkOut.refClk)
    else $error("shift clock started during blank");

  a_counter_reset: assert property (
    cntReset |=> s.cnt == 7'h00 && !clkOut.refClk && !clkOut.shiftClk
      && clkOut.videoClockOut ##1 s.cnt == 7'h01)
    else $error("counter reset code did not reset the clocks");

  a_clock_phase: assert property (
    s.ocs[2:0] == s.ocs[5:3] && s.ocs[2:0] != 3'h7 |-> clkOut.refClk == clkOut.videoClockOut)
    else $error("video and reference clocks out of phase");

  a_sample_edge: assert property (
    $changed(vidSampled) |-> ($past(s.cfgInvert) ? $rose(clkOut.videoClockOut)
      : $fell(clkOut.videoClockOut)))
    else $error("video controls sampled off the video clock edge");

  a_reset_state: assert property (
    $rose(rstSyncN) |-> s.ocs == OCS_RST && !clkOut.shiftClk && clkOut.videoClockOut)
    else $error("wrong clock state after reset");

  a_src_ecl: assert property (
    wrIcs && apbReq.pwdata[7:0] == 8'h07 |=> srcOut.index == 3'h1 && srcOut.diff
      && !srcOut.double)
    else $error("code 07 did not select pair one two");

  a_src_double: assert property (
    wrIcs && apbReq.pwdata[7:0] == 8'h16 |=> srcOut.index == 3'h3 && srcOut.diff
      && srcOut.double)
    else $error("code 16 did not select doubled pair three four");

  a_src_reset: assert property (
    $rose(rstSyncN) |-> srcOut.index == 3'h0 && !srcOut.diff && !srcOut.double)
    else $error("reset did not select input zero");

  a_half_period: assert property (
    s.ocs[2:0] == 3'h1 && $past(s.ocs[2:0]) == 3'h1 && $past(s.ocs[2:0], 2) == 3'h1
      && !$past(cntReset) && !$past(cntReset, 2) && $rose(clkOut.refClk)
      |=> (clkOut.refClk || s.ocs[2:0] != 3'h1) ##1 (!clkOut.refClk || s.ocs[2:0] != 3'h1))
    else $error("divide by two lost its duty cycle");

  // Video clock checks mirror the reference ones; a new code may cut a phase short
  a_video_div_one: assert property (
    s.ocs[5:3] == 3'h0 && $past(s.ocs[5:3]) == 3'h0 && !$past(cntReset)
      |-> clkOut.videoClockOut != $past(clkOut.videoClockOut))
    else $error("video clock not toggling at divide by one");

  a_video_half: assert property (
    s.ocs[5:3] == 3'h1 && $past(s.ocs[5:3]) == 3'h1 && $past(s.ocs[5:3], 2) == 3'h1
      && !$past(cntReset) && !$past(cntReset, 2) && $rose(clkOut.videoClockOut)
      |=> (clkOut.videoClockOut || s.ocs[5:3] != 3'h1)
      ##1 (!clkOut.videoClockOut || s.ocs[5:3] != 3'h1))
    else $error("video divide by two lost its duty cycle");

  // Shift gating: blank stops new high phases but never cuts one short
  a_shift_needs_ref: assert property (
    clkOut.shiftClk |-> clkOut.refClk)
    else $error("shift clock high while reference clock low");

  a_shift_blank_hold: assert property (
    !s.vid.systemBlankIn && !clkOut.shiftClk |=> !clkOut.shiftClk)
    else $error("shift clock restarted during blank");

  a_shift_runs: assert property (
    s.ocs[6] && $past(s.vid.systemBlankIn) |-> clkOut.shiftClk == clkOut.refClk)
    else $error("enabled shift clock not following the reference clock");

  // The first edge after release has no earlier count to compare against
  a_cnt_advance: assert property (
    $past(rstSyncN) && !$past(cntReset) |-> s.cnt == $past(s.cnt) + 7'h01)
    else $error("shared counter skipped a dot clock step");

  a_ref_reset_div: assert property (
    $rose(rstSyncN) |-> s.ocs[2:0] == 3'h6 && !clkOut.refClk)
    else $error("reference clock not at slowest ratio after reset");

  // Source decode spot checks for codes that software commonly writes
  a_src_ttl: assert property (
    wrIcs && apbReq.pwdata[7:0] == 8'h04 |=> srcOut.index == 3'h4 && !srcOut.diff
      && !srcOut.double)
    else $error("code 04 did not select input four");

  a_src_ttl_double: assert property (
    wrIcs && apbReq.pwdata[7:0] == 8'h10 |=> srcOut.index == 3'h0 && !srcOut.diff
      && srcOut.double)
    else $error("code 10 did not select doubled input zero");

  a_src_dont_care: assert property (
    wrIcs && apbReq.pwdata[7:0] == 8'h8A |=> srcOut.index == 3'h2 && !srcOut.diff
      && !srcOut.double)
    else $error("ignored source bits changed the selection");
endmodule

// ==== pcg_clock_gen_tb.sv ====
// Testbench for the palette clock generator
`timescale 1ns/1ps
module pcg_clock_gen_tb;
  import pcg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pcg_apb_req_s apbReq = '0;
  pcg_apb_rsp_s apbRsp;
  pcg_clk_s clkOut;
  pcg_vid_s vidIn;
  pcg_vid_s vidSampled;
  pcg_src_s srcOut;
  logic settling;
  logic [4:0] pins;
  logic blankReq = 1'b1;
  logic syncReq = 1'b1;
  logic invert = 1'b0;
  int num_errors = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic err;
  int n;
  int bad;
  logic [7:0] codes [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07,
    8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h17};
  always #2.5 clk = ~clk;
  pcg_clock_gen u_pcg_clock_gen (.clk(clk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
    .clockInputZero(pins[0]), .clockInputOne(pins[1]), .clockInputTwo(pins[2]),
    .clockInputThree(pins[3]), .clockInputFour(pins[4]), .vidIn(vidIn), .clkOut(clkOut),
    .vidSampled(vidSampled), .srcOut(srcOut), .settling(settling));
  pcg_gfx_partner u_pcg_gfx_partner (.clk(clk), .rst_n(rst_n),
    .videoClockOut(clkOut.videoClockOut), .invert(invert), .blankReq(blankReq),
    .syncReq(syncReq), .clockPins(pins), .vidIn(vidIn));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    // No cycle count assumed: only the watchdog ends a wait for pready
    do begin
      @(posedge clk);
    end while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  task automatic halfper(input int b);
    logic v;
    int i;
    @(posedge clk);
    v = clkOut[b];
    i = 0;
    while (clkOut[b] === v && i < 300) begin
      @(posedge clk);
      i++;
    end
    v = clkOut[b];
    n = 0;
    while (clkOut[b] === v && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask
  // Pair mode: all three clocks must match; else masked outputs must hold expv
  task automatic watch(input logic [2:0] mask, input logic [2:0] expv, input logic pair);
    bad = 0;
    repeat (130) begin
      @(posedge clk);
      if (pair ? (clkOut.refClk !== clkOut.videoClockOut || clkOut.shiftClk !== clkOut.refClk)
          : ((3'(clkOut) & mask) !== expv)) bad++;
    end
  endtask
  function automatic logic [4:0] expSrc(input logic [7:0] c);
    logic [2:0] idx;
    idx = (c[2:0] == 3'h6) ? 3'h3 : ((c[2:0] == 3'h7) ? 3'h1 : c[2:0]);
    return {idx, c[2:1] == 2'b11, c[4]};
  endfunction
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(3'(clkOut), 3'b001);
    apb(1'b0, OCS_ADDR, 8'h00); chk(rd, 32'h3E);
    apb(1'b0, ICS_ADDR, 8'h00); chk(rd, 32'h00);
    chk(srcOut.index, 0);
    halfper(2); chk(n, 64);
    apb(1'b0, 12'h010, 8'h00); chk(err, 1); // unmapped
    chk(rd, 0);
    for (int k = 0; k < 7; k++) begin
      // Bit 7 set throughout to show it has no effect
      apb(1'b1, OCS_ADDR, {2'b11, 3'(k), 3'(k)});
      halfper(2); chk(n, 1 << k);
      halfper(0); chk(n, 1 << k);
      watch(3'h0, 3'h0, 1'b1); chk(bad, 0);
    end
    blankReq <= 1'b0;
    repeat (400) @(posedge clk);
    chk(vidSampled.systemBlankIn, 0);
    watch(3'b010, 3'b000, 1'b0); chk(bad, 0);
    halfper(2); chk(n, 64);
    blankReq <= 1'b1;
    apb(1'b1, CFG_ADDR, 8'h01);
    invert <= 1'b1;
    syncReq <= 1'b0;
    repeat (400) @(posedge clk);
    chk(vidSampled.hsync, 0);
    chk(vidSampled.vsync, 1);
    // Shift clock unused from here on, so software switches it off
    apb(1'b1, OCS_ADDR, 8'h09);
    watch(3'b010, 3'b000, 1'b0); chk(bad, 0);
    halfper(2); chk(n, 2);
    // Single part on this bench, so no dot clock gating is needed around the reset
    apb(1'b1, OCS_ADDR, 8'h3F);
    apb(1'b0, STAT_ADDR, 8'h00); chk(rd[14:8] < 7'd8, 1);
    watch(3'b111, 3'b001, 1'b0); chk(bad, 0);
    for (int i = 0; i < 14; i++) begin
      apb(1'b1, ICS_ADDR, codes[i]);
      apb(1'b0, ICS_ADDR, 8'h00); chk(rd, codes[i]);
      chk({srcOut.index, srcOut.diff, srcOut.double}, expSrc(codes[i]));
    end
    apb(1'b1, ICS_ADDR, 8'h8A);
    #1 chk(settling, 1);
    apb(1'b0, ICS_ADDR, 8'h00);
    chk({srcOut.index, srcOut.diff, srcOut.double}, expSrc(8'h02));
    repeat (8) @(posedge clk);
    chk(settling, 0);
    end_of_test();
  end
endmodule

// ==== pcg_gfx_partner.sv ====
// Graphics control logic model: source clock pins and video control inputs
`timescale 1ns/1ps
module pcg_gfx_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic videoClockOut,
  input wire logic invert,
  input wire logic blankReq,
  input wire logic syncReq,
  output logic [4:0] clockPins,
  output pcg_pkg::pcg_vid_s vidIn
);
  import pcg_pkg::*;
  logic [6:0] cntFf;
  logic vPrevFf;
  // Distinct rates per pin so a wrong source pick shows up
  assign clockPins = cntFf[6:2];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cntFf <= 7'h00;
      vPrevFf <= 1'b1;
      vidIn <= '{hsync: 1'b1, vsync: 1'b1, systemBlankIn: 1'b1};
    end else begin
      cntFf <= cntFf + 7'h01;
      vPrevFf <= videoClockOut;
      // Launch on the edge opposite the sampling one; held video clock freezes controls
      if (videoClockOut !== vPrevFf && videoClockOut === !invert) begin
        vidIn <= '{hsync: syncReq, vsync: !syncReq, systemBlankIn: blankReq};
      end
    end
  end
endmodule

// ==== pcg_pkg.sv ====
// Constants and types for the palette clock generator
// Function
// - Reference clock runs free, never blanked, dot clock divided by 1 to 64.
// - Divide bits 5:3 set video clock ratio; code 7 holds it high.
// - Divide bits 2:0 set reference ratio; code 7 holds reference and shift low.
// - Bit 6 enables shift clock output, default off and low; bit 7 ignored.
// - Shift clock follows reference ratio but is suppressed during blank.
// - Writing 3F resets the shared counter; reference, shift low, video high.
// - All three clocks come from one counter advanced each dot clock edge.
// - Sync and blank sampled on falling video clock, rising when polarity inverted.
// - After reset reference divides by 64, shift low, video high.
// - Source codes 00-04 pick TTL inputs 0-4; 06 and 07 pick ECL pairs.
// - Codes 10-14, 16, 17 pick the same sources with frequency doubling.
// - Source bits 3 and 7 ignored; bits 5 and 6 reserved.
// - Reset selects clock input zero as TTL source, code 00.
package pcg_pkg;
  localparam int CLK_MHZ = 200;
  localparam int SETTLE_NS = 30;
  localparam logic [2:0] SETTLE_CYC = 3'((SETTLE_NS * CLK_MHZ + 999) / 1000);

  localparam logic [11:0] OCS_ADDR = 12'h000;
  localparam logic [11:0] ICS_ADDR = 12'h004;
  localparam logic [11:0] CFG_ADDR = 12'h008;
  localparam logic [11:0] STAT_ADDR = 12'h00C;

  localparam logic [7:0] OCS_RST = 8'h3E;
  localparam logic [7:0] ICS_RST = 8'h00;
  localparam logic CFG_RST = 1'b0;
  localparam logic [6:0] CNT_RESET_CODE = 7'h3F;
  localparam logic [2:0] HELD_CODE = 3'h7;

  localparam int OCS_REF_LSB = 0;
  localparam int OCS_VID_LSB = 3;
  localparam int OCS_SHIFT_EN = 6;
  localparam int ICS_DOUBLE = 4;

  localparam int ST_REF = 0;
  localparam int ST_SHIFT = 1;
  localparam int ST_VIDEO = 2;
  localparam int ST_SETTLE = 3;
  localparam int ST_HSYNC = 4;
  localparam int ST_VSYNC = 5;
  localparam int ST_BLANK = 6;
  localparam int ST_LEVEL = 7;
  localparam int ST_CNT_LSB = 8;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pcg_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pcg_apb_rsp_s;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic systemBlankIn;
  } pcg_vid_s;

  typedef struct packed {
    logic refClk;
    logic shiftClk;
    logic videoClockOut;
  } pcg_clk_s;

  typedef struct packed {
    logic [2:0] index;
    logic diff;
    logic double;
    logic level;
  } pcg_src_s;

  typedef struct packed {
    logic [7:0] ocs;
    logic [7:0] ics;
    logic cfgInvert;
    logic [6:0] cnt;
    pcg_clk_s clk;
    pcg_vid_s vid;
    pcg_src_s src;
    logic [2:0] settle;
    logic busy;
    pcg_apb_rsp_s rsp;
  } pcg_state_s;

  localparam pcg_clk_s CLK_RST = '{refClk: 1'b0, shiftClk: 1'b0, videoClockOut: 1'b1};
  localparam pcg_vid_s VID_RST = '{hsync: 1'b1, vsync: 1'b1, systemBlankIn: 1'b0};
  localparam pcg_src_s SRC_RST = '{index: 3'h0, diff: 1'b0, double: 1'b0, level: 1'b0};
  localparam pcg_apb_rsp_s RSP_RST = '{prdata: 32'h0, pready: 1'b0, pslverr: 1'b0};
  localparam pcg_state_s STATE_RST = '{ocs: OCS_RST, ics: ICS_RST, cfgInvert: CFG_RST,
    cnt: 7'h00, clk: CLK_RST, vid: VID_RST, src: SRC_RST, settle: 3'h0, busy: 1'b0,
    rsp: RSP_RST};
endpackage

// ==== pcg_sync_bank.sv ====
// Two-flop synchroniser bank for the clock and video control pins
`timescale 1ns/1ps
module pcg_sync_bank (
  input wire logic clk,
  input wire logic rstSyncN,
  input wire logic [7:0] din,
  output logic [7:0] dout
);
  import pcg_pkg::*;

  typedef struct packed {
    logic [7:0] meta;
    logic [7:0] sync;
  } pcg_sync_s;

  pcg_sync_s s;
  pcg_sync_s n;

  always_comb begin
    n = s;
    n.meta = din;
    n.sync = s.meta;
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign dout = s.sync;
endmodule
